// ==== logic/conversion_start_stop_control.sv ====
// Top level of the conversion start/stop control register and its four converter groups.
`include "conv_ctrl_map.svh"

// Overview of operation
// - Pair A begin bit starts or restarts enabled current and voltage converters A.
// - Pair B begin bit starts or restarts enabled current and voltage converters B.
// - All begin bits are triggers only and always read back zero.
// - Pair A halt bit stops continuous run after the conversion in flight completes.
// - Pair B halt bit stops continuous run after the conversion in flight completes.
// - Pair halt bits are ignored in single-shot mode.
// - Begin and halt of one pair in one write: begin wins.
// - Pair A halt self-clears at conversion end, or on begin which aborts and restarts.
// - Pair B halt self-clears at conversion end, or on begin which aborts and restarts.
// - Sequencer A begin starts or restarts multiplexed converter A's sequence.
// - Sequencer B begin starts or restarts multiplexed converter B's sequence.
// - Sequencer A halt ends its sequence once the running sequence finishes.
// - Sequencer B halt ends its sequence once the running sequence finishes.
// - Begin and halt of one sequencer in one write: begin wins.
// - Sequencer A halt clears at sequence end, or on begin which aborts and relaunches.
// - Sequencer B halt clears at sequence end, or on begin which aborts and relaunches.
//
// Register layout, one 16-bit word at the control address.
// Bit 14 is the pair A begin trigger.
// Bit 12 is the pair B begin trigger.
// Bit 10 is the pair A halt request, read back while the halt is pending.
// Bit 8 is the pair B halt request, read back while the halt is pending.
// Bit 6 is the sequencer A begin trigger.
// Bit 4 is the sequencer B begin trigger.
// Bit 2 is the sequencer A halt request, read back while the halt is pending.
// Bit 0 is the sequencer B halt request, read back while the halt is pending.
// All odd bits are reserved and always read zero.
//
// A write is decoded into one-cycle strobes, so a trigger bit never lingers in storage.
// That is why the begin bits read zero without any extra clearing logic.
// The halt bits shown on readback are the pending state of each group, not the written value.
// This lets software poll a halt bit until the unit in flight has finished.
// The trade-off is that a halt written to an idle group is never seen on readback.
module conversion_start_stop_control
    import conv_ctrl_pkg::*;
(
    input  wire logic        I_MCLK,
    input  wire logic        I_RESET,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    input  wire logic [7:0]  I_ADDR,
    input  wire logic [15:0] I_WDATA,
    output logic      [15:0] O_RDATA,
    output logic             O_RVALID,
    input  wire logic        I_SINGLE_SHOT,
    input  wire logic [3:0]  I_UNIT_DONE,
    output logic      [3:0]  O_START,
    output logic      [3:0]  O_ABORT,
    output logic      [3:0]  O_RUNNING
);
    // Group index: 0 pair A, 1 pair B, 2 sequencer A, 3 sequencer B.
    localparam int NGRP = 4;

    logic [15:0]     strobe;
    logic [NGRP-1:0] begin_s;
    logic [NGRP-1:0] halt_s;
    logic [NGRP-1:0] single_s;
    logic [NGRP-1:0] pend;

    typedef struct packed {
        logic [15:0] rdata;
        logic        rvalid;
    } top_t;

    top_t st_r;
    top_t st_nxt;

    conv_write_decode u_dec (
        .I_MCLK   (I_MCLK),
        .I_RESET  (I_RESET),
        .i_wr     (I_WR),
        .i_addr   (I_ADDR),
        .i_wdata  (I_WDATA),
        .o_strobe (strobe)
    );

    // Field map from the decoded write to the four groups.
    assign begin_s = {strobe[`BIT_SEQ_B_BEGIN], strobe[`BIT_SEQ_A_BEGIN],
                      strobe[`BIT_PAIR_B_BEGIN], strobe[`BIT_PAIR_A_BEGIN]};
    assign halt_s  = {strobe[`BIT_SEQ_B_HALT], strobe[`BIT_SEQ_A_HALT],
                      strobe[`BIT_PAIR_B_HALT], strobe[`BIT_PAIR_A_HALT]};
    // Single-shot only concerns the pairs; sequencers always honour halt.
    assign single_s = {2'b00, I_SINGLE_SHOT, I_SINGLE_SHOT};

    // One controller per group; begin overrides halt and aborts work in flight.
    genvar g;
    generate
        for (g = 0; g < NGRP; g++) begin : g_grp
            stream_ctrl u_ctl (
                .I_MCLK         (I_MCLK),
                .I_RESET        (I_RESET),
                .i_begin        (begin_s[g]),
                .i_halt         (halt_s[g]),
                .i_single_shot  (single_s[g]),
                .i_unit_done    (I_UNIT_DONE[g]),
                .o_start        (O_START[g]),
                .o_abort        (O_ABORT[g]),
                .o_running      (O_RUNNING[g]),
                .o_halt_pending (pend[g])
            );
        end
    endgenerate

    // Readback: begin bits and reserved bits are always zero; halt bits show pending stops.
    always_comb begin
        st_nxt        = st_r;
        st_nxt.rvalid = I_RD;
        if (I_RD) begin
            st_nxt.rdata = 16'h0000;
            if (I_ADDR == `CONV_REG_ADDR) begin
                st_nxt.rdata[`BIT_PAIR_A_HALT] = pend[0];
                st_nxt.rdata[`BIT_PAIR_B_HALT] = pend[1];
                st_nxt.rdata[`BIT_SEQ_A_HALT]  = pend[2];
                st_nxt.rdata[`BIT_SEQ_B_HALT]  = pend[3];
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            st_r <= '{rdata: `CONV_REG_RESET, rvalid: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign O_RDATA  = st_r.rdata;
    assign O_RVALID = st_r.rvalid;

    // Assertions.
    begin_wins_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        begin_s[0] |=> O_START[0] && O_RUNNING[0]) else $error("pair A begin not honoured");
    begin_b_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        begin_s[1] |=> O_START[1]) else $error("pair B begin not honoured");
    seq_begin_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (begin_s[2] && halt_s[2]) |=> O_START[2] && O_RUNNING[2]) else $error("sequencer begin lost");
    read_zero_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        O_RVALID |-> (O_RDATA & 16'hfafa) == 16'h0000) else $error("begin or reserved bit read one");
    halt_drain_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (halt_s[2] && !begin_s[2] && O_RUNNING[2] && !I_UNIT_DONE[2]) |=> O_RUNNING[2])
        else $error("sequencer halted early");
    halt_end_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (pend[3] && I_UNIT_DONE[3] && !begin_s[3]) |=> !O_RUNNING[3] && !pend[3])
        else $error("halt not cleared at end");
    single_ign_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (I_SINGLE_SHOT && halt_s[1] && !begin_s[1]) |=> !pend[1]) else $error("halt acted in single shot");
    abort_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (begin_s[0] && pend[0] && !I_UNIT_DONE[0]) |=> O_ABORT[0] && !pend[0]) else $error("no abort");
    rsvd_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (I_WR && I_ADDR == `CONV_REG_ADDR) |=> (strobe & 16'haaaa) == 16'h0000) else $error("reserved write");
    restart_c: cover property (@(posedge I_MCLK) O_ABORT[0]);
    drain_c: cover property (@(posedge I_MCLK) pend[2] ##1 !O_RUNNING[2]);
    both_c: cover property (@(posedge I_MCLK) begin_s[1] && halt_s[1]);
    single_c: cover property (@(posedge I_MCLK) I_SINGLE_SHOT && O_START[0]);
    seq_stop_c: cover property (@(posedge I_MCLK) pend[3] ##1 !O_RUNNING[3]);

    // Read strobe answers exactly one cycle later, and only then.
    rvalid_set_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        I_RD |=> O_RVALID) else $error("read not answered");
    rvalid_clr_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        !I_RD |=> !O_RVALID) else $error("spurious read valid");

    // Reads of any other address return zero.
    other_addr_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (I_RD && I_ADDR != `CONV_REG_ADDR) |=> O_RDATA == 16'h0000)
        else $error("other address read nonzero");

    // Halt bits read back the pending state at the read strobe.
    halt_read_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (I_RD && I_ADDR == `CONV_REG_ADDR) |=>
        {O_RDATA[`BIT_PAIR_A_HALT], O_RDATA[`BIT_PAIR_B_HALT], O_RDATA[`BIT_SEQ_A_HALT], O_RDATA[`BIT_SEQ_B_HALT]}
        == $past({pend[0], pend[1], pend[2], pend[3]}))
        else $error("halt readback mismatch");

    // Per-group checks, one copy for each converter group.
    generate
        for (g = 0; g < NGRP; g++) begin : g_chk
            // A start pulse follows each begin strobe by one cycle and never appears otherwise.
            start_follow_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
                O_START[g] == $past(begin_s[g])) else $error("start pulse mismatch");
            // Abort is only ever a companion of a restart.
            abort_start_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
                O_ABORT[g] |-> O_START[g]) else $error("abort without start");
            // Starting an idle group has nothing to abort.
            abort_idle_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
                (begin_s[g] && !O_RUNNING[g]) |=> !O_ABORT[g]) else $error("abort from idle");
            // Any begin leaves the group running.
            begin_run_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
                begin_s[g] |=> O_RUNNING[g]) else $error("group not running");
            // Any begin wipes a pending halt.
            begin_clr_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
                begin_s[g] |=> !pend[g]) else $error("halt survived begin");
            // A pending halt waits for the unit in flight.
            halt_wait_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
                (pend[g] && !I_UNIT_DONE[g] && !begin_s[g]) |=> O_RUNNING[g] && pend[g])
                else $error("halt did not wait");
            // The end of the unit in flight clears the halt and stops the group.
            halt_done_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
                (pend[g] && I_UNIT_DONE[g] && !begin_s[g]) |=> !O_RUNNING[g] && !pend[g])
                else $error("halt not cleared");
            // A pending halt implies a running group.
            pend_run_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
                pend[g] |-> O_RUNNING[g]) else $error("halt pending while idle");
            // An idle group stays quiet until it is started.
            idle_quiet_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
                (!O_RUNNING[g] && !begin_s[g]) |=> !O_RUNNING[g] && !O_START[g])
                else $error("idle group woke");
            // A halt to an idle group leaves nothing behind.
            halt_idle_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
                (halt_s[g] && !begin_s[g] && !O_RUNNING[g]) |=> !pend[g])
                else $error("halt stuck on idle group");
            if (g < 2) begin : g_pair
                // A single-shot pair start never shows a pending halt.
                single_start_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
                    (begin_s[g] && I_SINGLE_SHOT) |=> !pend[g]) else $error("single shot halt shown");
            end else begin : g_seq
                // A sequencer always takes a halt, whatever the pair mode.
                seq_halt_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
                    (halt_s[g] && !begin_s[g] && O_RUNNING[g] && !I_UNIT_DONE[g]) |=> pend[g])
                    else $error("sequencer halt lost");
            end
        end
    endgenerate
endmodule

// ==== logic/conv_ctrl_map.svh ====
// Register offset, field positions, reset value and widths of the conversion start/stop register.
`ifndef CONV_CTRL_MAP_SVH
`define CONV_CTRL_MAP_SVH
`define CONV_REG_ADDR      8'h09
`define CONV_REG_RESET     16'h0000
`define CONV_REG_WIDTH     16
`define CONV_ADDR_WIDTH    8
`define BIT_PAIR_A_BEGIN   14
`define BIT_PAIR_B_BEGIN   12
`define BIT_PAIR_A_HALT    10
`define BIT_PAIR_B_HALT    8
`define BIT_SEQ_A_BEGIN    6
`define BIT_SEQ_B_BEGIN    4
`define BIT_SEQ_A_HALT     2
`define BIT_SEQ_B_HALT     0
`define CONV_RW_MASK       16'h5555
`endif

// ==== logic/conv_ctrl_pkg.sv ====
// Types shared by the conversion start/stop control block.
package conv_ctrl_pkg;
    // Run state of one converter group.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DRAIN
    } run_state_t;
endpackage

// ==== logic/stream_ctrl.sv ====
// Start/stop controller for one converter group: a pair or a sequencer.
module stream_ctrl
    import conv_ctrl_pkg::*;
(
    input  wire logic I_MCLK,
    input  wire logic I_RESET,
    input  wire logic i_begin,
    input  wire logic i_halt,
    input  wire logic i_single_shot,
    input  wire logic i_unit_done,
    output logic      o_start,
    output logic      o_abort,
    output logic      o_running,
    output logic      o_halt_pending
);
    typedef struct packed {
        run_state_t state;
        logic       start;
        logic       abort;
        logic       single;
    } ctl_t;

    ctl_t st_r;
    ctl_t st_nxt;

    // A begin always wins over a halt in the same write; a halt waits for the unit in flight.
    always_comb begin
        st_nxt       = st_r;
        st_nxt.start = 1'b0;
        st_nxt.abort = 1'b0;
        if (i_begin) begin
            st_nxt.start = 1'b1;
            st_nxt.abort = (st_r.state != ST_IDLE) && !i_unit_done;
            st_nxt.state  = i_single_shot ? ST_DRAIN : ST_RUN;
            st_nxt.single = i_single_shot;
        end else begin
            case (st_r.state)
                ST_RUN: begin
                    if (i_halt && !i_single_shot) begin
                        st_nxt.state = i_unit_done ? ST_IDLE : ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (i_unit_done) begin
                        st_nxt.state = ST_IDLE;
                    end
                end
                default: begin
                    st_nxt.state = ST_IDLE;
                end
            endcase
        end
    end

    // State register, synchronous reset.
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            st_r <= '{state: ST_IDLE, start: 1'b0, abort: 1'b0, single: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pending halt is only visible while draining a continuous run, not a single shot.
    assign o_start        = st_r.start;
    assign o_abort        = st_r.abort;
    assign o_running      = st_r.state != ST_IDLE;
    assign o_halt_pending = (st_r.state == ST_DRAIN) && !st_r.single;
endmodule

// ==== logic/conv_write_decode.sv ====
// Decoder of register writes into one-cycle begin and halt strobes for the control register.
module conv_write_decode
    import conv_ctrl_pkg::*;
(
    input  wire logic        I_MCLK,
    input  wire logic        I_RESET,
    input  wire logic        i_wr,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_strobe
);
`include "conv_ctrl_map.svh"
    typedef struct packed {
        logic [15:0] strobe;
    } dec_t;

    dec_t st_r;
    dec_t st_nxt;

    // Reserved odd bits are masked off, so writes to them have no effect.
    always_comb begin
        st_nxt.strobe = 16'h0000;
        if (i_wr && (i_addr == `CONV_REG_ADDR)) begin
            st_nxt.strobe = i_wdata & `CONV_RW_MASK;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            st_r.strobe <= `CONV_REG_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_strobe = st_r.strobe;
endmodule

// ==== testbench/conv_unit_model.sv ====
// Converter group model: each started group reports a finished conversion after a fixed delay.
module conv_unit_model #(
    parameter int LAT = 20
) (
    input  wire logic       I_MCLK,
    input  wire logic       I_RESET,
    input  wire logic [3:0] i_start,
    input  wire logic [3:0] i_running,
    output logic      [3:0] o_done
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt [4];
    // A start reloads the delay, so a restart never sees a stale done from the aborted conversion.
    always @(posedge I_MCLK) begin
        for (int g = 0; g < 4; g++) begin
            o_done[g] <= 1'b0;
            if (I_RESET || i_start[g]) begin
                cnt[g] <= LAT;
            end else if (i_running[g]) begin
                if (cnt[g] == 0) begin
                    o_done[g] <= 1'b1;
                    cnt[g] <= LAT;
                end else begin
                    cnt[g] <= cnt[g] - 1;
                end
            end
        end
    end
endmodule

// ==== testbench/conversion_start_stop_control_tb.sv ====
// Bench for the conversion start/stop register: register writes and reads against a converter model.
`include "conv_ctrl_map.svh"
module conversion_start_stop_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        I_MCLK = 1'b0;
    logic        I_RESET = 1'b1;
    logic        I_WR = 1'b0;
    logic        I_RD = 1'b0;
    logic [7:0]  I_ADDR = 8'h00;
    logic [15:0] I_WDATA = 16'h0000;
    logic        I_SINGLE_SHOT = 1'b0;
    logic [15:0] O_RDATA;
    logic        O_RVALID;
    logic [3:0]  I_UNIT_DONE;
    logic [3:0]  O_START;
    logic [3:0]  O_ABORT;
    logic [3:0]  O_RUNNING;
    int          fails = 0;
    int          n_tests = 0;

    // Half period of the 20 MHz clock.
    always #25 I_MCLK = ~I_MCLK;

    conversion_start_stop_control u_conversion_start_stop_control (
        .I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_WR(I_WR), .I_RD(I_RD), .I_ADDR(I_ADDR),
        .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_SINGLE_SHOT(I_SINGLE_SHOT),
        .I_UNIT_DONE(I_UNIT_DONE), .O_START(O_START), .O_ABORT(O_ABORT), .O_RUNNING(O_RUNNING));

    conv_unit_model u_conv_unit_model (
        .I_MCLK(I_MCLK), .I_RESET(I_RESET), .i_start(O_START), .i_running(O_RUNNING), .o_done(I_UNIT_DONE));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One write frame; returns on the clock edge that registers the resulting start pulse.
    task automatic wr(input logic [15:0] d);
        @(posedge I_MCLK);
        I_WR <= 1'b1;
        I_ADDR <= `CONV_REG_ADDR;
        I_WDATA <= d;
        @(posedge I_MCLK);
        I_WR <= 1'b0;
        @(posedge I_MCLK);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge I_MCLK);
        I_RD <= 1'b1;
        I_ADDR <= a;
        @(posedge I_MCLK);
        I_RD <= 1'b0;
        #1;
        chk("read valid", 16'h0001, {15'h0000, O_RVALID});
        chk(what, exp, O_RDATA);
    endtask

    task automatic go(input logic [15:0] d, input logic [3:0] st, input logic [3:0] ab);
        wr(d);
        #1;
        chk("start pulse", {12'h000, st}, {12'h000, O_START});
        chk("abort pulse", {12'h000, ab}, {12'h000, O_ABORT});
    endtask

    // Bounded wait: a group that never finishes shows up as a running mismatch.
    task automatic wait_idle;
        for (int i = 0; i < 60 && O_RUNNING !== 4'h0; i++) @(posedge I_MCLK);
        #1;
        chk("running", 16'h0000, {12'h000, O_RUNNING});
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge I_MCLK);
        I_RESET <= 1'b0;
        rd(`CONV_REG_ADDR, 16'h0000, "reset value");
        // Every bit set in one frame: begins act, halts and reserved bits do not.
        go(16'hffff, 4'hf, 4'h0);
        rd(`CONV_REG_ADDR, 16'h0000, "begin beats halt");
        // Halts stand while conversions continue, then clear when the conversion ends.
        wr(16'h0505);
        rd(`CONV_REG_ADDR, 16'h0505, "halt pending");
        wait_idle();
        rd(`CONV_REG_ADDR, 16'h0000, "halt cleared");
        // Begin with halts pending aborts and restarts every group.
        go(16'h5050, 4'hf, 4'h0);
        wr(16'h0505);
        go(16'h5050, 4'hf, 4'hf);
        rd(`CONV_REG_ADDR, 16'h0000, "halt cleared by begin");
        wr(16'h0505);
        wait_idle();
        // Single-shot pairs ignore halts; sequencers still take theirs.
        @(posedge I_MCLK);
        I_SINGLE_SHOT <= 1'b1;
        go(16'h5050, 4'hf, 4'h0);
        wr(16'h0505);
        rd(`CONV_REG_ADDR, 16'h0005, "single shot halt");
        wait_idle();
        rd(8'h08, 16'h0000, "other address");
        end_sim();
    end

    // About 100 cycles are expected; allow far more before declaring a hang.
    initial begin
        #(50 * 3000);
        fails++;
        end_sim();
    end
endmodule
